/* core/irq_params.svh */
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// Register offsets on the host register port.
`define OFS_INTERRUPT_ENABLE    8'h90
`define OFS_INTERRUPT_STATUS    8'h92

// Bit positions in the enable and status registers; bit 0 is in the enable register only.
`define BIT_LINK_CHANGE         15
`define BIT_TX_DONE             14
`define BIT_RX_READY            13
`define BIT_RX_OVERRUN          11
`define BIT_TX_STOPPED          9
`define BIT_RX_STOPPED          8
`define BIT_TX_SPACE            6
`define BIT_WAKE_FRAME          5
`define BIT_WAKE_PACKET         4
`define BIT_LINKUP_WAKE         3
`define BIT_ENERGY_WAKE         2
`define BIT_DELAYED_ENERGY      0

// Writable enable bits: all but bit 1, which is read-only zero.
`define ENABLE_WRITE_MASK       16'hfffd
// Host write-one-to-clear status bits.
`define STATUS_W1C_MASK         16'h6b40
`define STATUS_W1C_MASK_LC      16'h8000
// Wake bits, cleared only through the power control register.
`define STATUS_WAKE_MASK        16'h003c

// Reset values.
`define RESET_ENABLE            16'h0000
`define RESET_STATUS            16'h0000

// One-hot wake clear codes written to power control bits 5..2.
`define WAKE_CLR_FRAME          4'h8
`define WAKE_CLR_PACKET         4'h4
`define WAKE_CLR_LINKUP         4'h2
`define WAKE_CLR_ENERGY         4'h1

`endif

/* core/irq_pkg.sv */
package irq_pkg;

    // Host access decode states.
    typedef enum logic [1:0] {
        acc_idle  = 2'b00,
        acc_write = 2'b01,
        acc_read  = 2'b11
    } access_state_t;

    typedef logic [15:0] reg16_t;

endpackage : irq_pkg

/* core/flag_if.sv */
`timescale 1ns/1ps

// Carries one sticky flag's set, clear and held value.
interface flag_if;
    logic set;
    logic clear;
    logic value;
    modport owner (input set, input clear, output value);
    modport user  (output set, output clear, input value);
endinterface : flag_if

/* core/sticky_flag.sv */
`timescale 1ns/1ps

// One edge-set status flag: a rising edge on the source sets it, and
// set beats clear in the same cycle so that no event is lost.
module sticky_flag (
    // Clock and reset.
    input  wire logic clock_in,
    input  wire logic nrst_in,
    // Raw event level.
    input  wire logic level_in,
    // Flag handshake.
    flag_if.owner     flag
);
    logic prev_level;
    logic held;

    // Edge detector history.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= level_in;
        end
    end

    // Set on rising edge or pulse, clear only when no set arrives.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            held <= 1'b0;
        end else if ((level_in && !prev_level) || flag.set) begin
            held <= 1'b1;
        end else if (flag.clear) begin
            held <= 1'b0;
        end
    end

    assign flag.value = held;

endmodule : sticky_flag

/* core/interrupt_enable_status.sv */
`timescale 1ns/1ps
`include "irq_params.svh"

module interrupt_enable_status (
    // Clock and reset.
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // Host register port, 16-bit word access.
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    // Event sources from queue, MAC, PHY and power logic.
    input  wire logic        link_up_in,
    input  wire logic        tx_done_in,
    input  wire logic        rx_ready_in,
    input  wire logic        rx_overrun_in,
    input  wire logic        tx_stopped_in,
    input  wire logic        rx_stopped_in,
    input  wire logic        tx_space_in,
    input  wire logic        wake_frame_in,
    input  wire logic        wake_packet_in,
    input  wire logic        linkup_wake_in,
    input  wire logic        energy_wake_in,
    input  wire logic        host_ready_in,
    // Power control wake clear write.
    input  wire logic        pm_clear_wr_in,
    input  wire logic [3:0]  pm_clear_code_in,
    // Interrupt pin, active low.
    output logic             irq_n_out
);

    // ----------------------------------------------------------------
    // Register port decode
    // ----------------------------------------------------------------

    irq_pkg::reg16_t        interrupt_enable;
    irq_pkg::reg16_t        status_word;
    irq_pkg::access_state_t access;
    logic                   hit_enable;
    logic                   hit_status;
    logic                   status_wr;
    logic [15:0]            w1c;

    assign hit_enable = (reg_addr_in == `OFS_INTERRUPT_ENABLE);
    assign hit_status = (reg_addr_in == `OFS_INTERRUPT_STATUS);
    assign status_wr  = reg_wr_in && hit_status;
    // Only documented W1C bits accept a one; zeros do nothing.
    assign w1c = status_wr ? (reg_wdata_in & (`STATUS_W1C_MASK
                 | `STATUS_W1C_MASK_LC)) : 16'h0000;

    // Access classification; registered but not used by the read data path.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            access <= irq_pkg::acc_idle;
        end else if (reg_wr_in) begin
            access <= irq_pkg::acc_write;
        end else if (reg_rd_in) begin
            access <= irq_pkg::acc_read;
        end else begin
            access <= irq_pkg::acc_idle;
        end
    end

    // Enable register; bit 1 never stores a one.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            interrupt_enable <= `RESET_ENABLE;
        end else if (reg_wr_in && hit_enable) begin
            interrupt_enable <= reg_wdata_in & `ENABLE_WRITE_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------

    // Link change sets on either edge, so it uses its own history.
    logic link_prev;
    logic link_change_flag;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            link_prev <= 1'b0;
        end else begin
            link_prev <= link_up_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            link_change_flag <= 1'b0;
        end else if (link_up_in != link_prev) begin
            link_change_flag <= 1'b1;
        end else if (w1c[`BIT_LINK_CHANGE]) begin
            link_change_flag <= 1'b0;
        end
    end

    // Edge-set flags; index order matches src_levels below.
    localparam int NFLAG = 10;
    logic [NFLAG-1:0] src_levels;
    logic [NFLAG-1:0] flag_clear;
    logic [NFLAG-1:0] flag_value;

    assign src_levels = {tx_done_in, rx_ready_in, rx_overrun_in,
                         tx_stopped_in, rx_stopped_in, tx_space_in,
                         wake_frame_in, wake_packet_in, linkup_wake_in,
                         energy_wake_in};

    // Wake clear comes only from the power control code.
    logic pm_frame;
    logic pm_packet;
    logic pm_linkup;
    logic pm_energy;
    assign pm_frame  = pm_clear_wr_in
                       && (pm_clear_code_in == `WAKE_CLR_FRAME);
    assign pm_packet = pm_clear_wr_in
                       && (pm_clear_code_in == `WAKE_CLR_PACKET);
    assign pm_linkup = pm_clear_wr_in
                       && (pm_clear_code_in == `WAKE_CLR_LINKUP);
    assign pm_energy = pm_clear_wr_in
                       && (pm_clear_code_in == `WAKE_CLR_ENERGY);

    assign flag_clear = {w1c[`BIT_TX_DONE], w1c[`BIT_RX_READY],
                         w1c[`BIT_RX_OVERRUN], w1c[`BIT_TX_STOPPED],
                         w1c[`BIT_RX_STOPPED], w1c[`BIT_TX_SPACE],
                         pm_frame, pm_packet, pm_linkup, pm_energy};

    // Each instance keeps set-over-clear priority.
    for (genvar i = 0; i < NFLAG; i++) begin : g_flag
        flag_if fl ();
        assign fl.set   = 1'b0;
        assign fl.clear = flag_clear[i];
        assign flag_value[i] = fl.value;
        sticky_flag u_flag (
            .clock_in (clock_in),
            .nrst_in  (nrst_in),
            .level_in (src_levels[i]),
            .flag     (fl)
        );
    end

    // Assemble the status word; reserved bits stay zero.
    always_comb begin
        status_word = 16'h0000;
        status_word[`BIT_LINK_CHANGE] = link_change_flag;
        status_word[`BIT_TX_DONE]     = flag_value[9];
        status_word[`BIT_RX_READY]    = flag_value[8];
        status_word[`BIT_RX_OVERRUN]  = flag_value[7];
        status_word[`BIT_TX_STOPPED]  = flag_value[6];
        status_word[`BIT_RX_STOPPED]  = flag_value[5];
        status_word[`BIT_TX_SPACE]    = flag_value[4];
        status_word[`BIT_WAKE_FRAME]  = flag_value[3];
        status_word[`BIT_WAKE_PACKET] = flag_value[2];
        status_word[`BIT_LINKUP_WAKE] = flag_value[1];
        status_word[`BIT_ENERGY_WAKE] = flag_value[0];
    end

    // ----------------------------------------------------------------
    // Interrupt gating
    // ----------------------------------------------------------------

    // Energy wake may come through the plain or the delayed enable;
    // the delayed path waits until the host side is ready.
    logic energy_req;
    assign energy_req = status_word[`BIT_ENERGY_WAKE]
        && (interrupt_enable[`BIT_ENERGY_WAKE]
            || (interrupt_enable[`BIT_DELAYED_ENERGY]
                && host_ready_in));

    logic next_irq;
    assign next_irq =
        (status_word[`BIT_LINK_CHANGE]
         && interrupt_enable[`BIT_LINK_CHANGE])
        || (status_word[`BIT_TX_DONE]
            && interrupt_enable[`BIT_TX_DONE])
        || (status_word[`BIT_RX_READY]
            && interrupt_enable[`BIT_RX_READY])
        || (status_word[`BIT_RX_OVERRUN]
            && interrupt_enable[`BIT_RX_OVERRUN])
        || |(status_word[9:8] & interrupt_enable[9:8])
        || (status_word[`BIT_TX_SPACE]
            && interrupt_enable[`BIT_TX_SPACE])
        || |(status_word[5:4] & interrupt_enable[5:4])
        || (status_word[`BIT_LINKUP_WAKE]
            && interrupt_enable[`BIT_LINKUP_WAKE])
        || energy_req;

    // Registered so the pin never glitches; costs one cycle latency.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            irq_n_out <= 1'b1;
        end else begin
            irq_n_out <= !next_irq;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------

    // Reads only sample; nothing here touches the flags.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            reg_rdata_out  <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in && !reg_wr_in;
            if (reg_rd_in && !reg_wr_in) begin
                case (1'b1)
                    hit_enable: reg_rdata_out <= interrupt_enable;
                    hit_status: reg_rdata_out <= status_word;
                    default:    reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end

endmodule : interrupt_enable_status

/* sim/interrupt_enable_status_props.sv */
`timescale 1ns/1ps
module interrupt_enable_status_props (
    // Clock and reset.
    input wire logic        clock_in,
    input wire logic        nrst_in,
    // Host register port.
    input wire logic [7:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        reg_rvalid_out,
    // Watched events and pin.
    input wire logic        link_up_in,
    input wire logic        rx_overrun_in,
    input wire logic        pm_clear_wr_in,
    input wire logic        irq_n_out
);
    logic [15:0] en;
    logic        rd_st;
    logic        rd_en;
    // Shadow enable so that pin checks know which sources are live.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            en <= 16'h0000;
        end else if (reg_wr_in && reg_addr_in == 8'h90) begin
            en <= reg_wdata_in & 16'hfffd;
        end
    end
    // Plain reads of each register.
    assign rd_st = reg_rd_in && !reg_wr_in && reg_addr_in == 8'h92;
    assign rd_en = reg_rd_in && !reg_wr_in && reg_addr_in == 8'h90;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    a_read_answer: assert property (
        reg_rd_in && !reg_wr_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_enable_readback: assert property (
        rd_en |=> reg_rdata_out == en) else $error("enable readback");
    a_status_reserved: assert property (
        rd_st |=> (reg_rdata_out & 16'h1483) == 16'h0000)
        else $error("reserved status bit set");
    a_unmapped_zero: assert property (
        reg_rd_in && !reg_wr_in && reg_addr_in != 8'h90
        && reg_addr_in != 8'h92 |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_read_keeps: assert property (
        rd_st && !pm_clear_wr_in ##1 rd_st && !pm_clear_wr_in |=>
        ($past(reg_rdata_out) & ~reg_rdata_out) == 16'h0000)
        else $error("status read cleared a bit");
    a_masked_quiet: assert property (
        en == 16'h0000 |=> irq_n_out) else $error("irq while masked");
    a_overrun_irq: assert property (
        $rose(rx_overrun_in) && en[11] && !reg_wr_in
        |-> ##[1:3] !irq_n_out) else $error("overrun irq missing");
    a_link_irq: assert property (
        $changed(link_up_in) && en[15] && !reg_wr_in
        |-> ##[1:3] !irq_n_out) else $error("link irq missing");
endmodule : interrupt_enable_status_props

bind interrupt_enable_status interrupt_enable_status_props chk_u (.*);

/* sim/host_model.sv */
`timescale 1ns/1ps
module host_model (
    // Clock.
    input  wire logic        clock_in,
    // Register port toward the device.
    output logic      [7:0]  reg_addr_out,
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    output logic      [15:0] reg_wdata_out,
    input  wire logic [15:0] reg_rdata_in,
    input  wire logic        reg_rvalid_in
);
    // Idle bus at time zero.
    initial begin
        reg_addr_out  = 8'h00;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        reg_wdata_out = 16'h0000;
    end
    // One word write; lines go to inverted junk so stale data never helps.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        reg_wr_out    <= 1'b1;
        @(posedge clock_in);
        reg_wr_out    <= 1'b0;
        reg_addr_out  <= ~a;
        reg_wdata_out <= ~d;
    endtask : wr
    // One word read; data and valid are taken after the edge settles.
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic v);
        @(posedge clock_in);
        reg_addr_out <= a;
        reg_rd_out   <= 1'b1;
        @(posedge clock_in);
        reg_rd_out   <= 1'b0;
        reg_addr_out <= ~a;
        #1;
        d = reg_rdata_in;
        v = reg_rvalid_in;
    endtask : rd
endmodule : host_model

/* sim/tb_interrupt_enable_status.sv */
`timescale 1ns/1ps
module tb_interrupt_enable_status;
    logic        clock_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [7:0]  addr;
    logic        wr, rd, rvalid, irq_n;
    logic [15:0] wdata, rdata, d;
    logic [15:0] ev = 16'h0000;
    logic        host_ready = 1'b0;
    logic        pm_wr = 1'b0;
    logic [3:0]  pm_code = 4'h0;
    logic [3:0]  wc;
    int          errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          b;
    int          srcs[12] = '{15, 15, 14, 13, 11, 9, 8, 6, 5, 4, 3, 2};
    // Clock and hang guard.
    always #12.5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end
    host_model hm (.clock_in(clock_in), .reg_addr_out(addr),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata),
        .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
    interrupt_enable_status dut_u (.clock_in(clock_in), .nrst_in(nrst_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .link_up_in(ev[15]),
        .tx_done_in(ev[14]), .rx_ready_in(ev[13]),
        .rx_overrun_in(ev[11]), .tx_stopped_in(ev[9]),
        .rx_stopped_in(ev[8]), .tx_space_in(ev[6]),
        .wake_frame_in(ev[5]), .wake_packet_in(ev[4]),
        .linkup_wake_in(ev[3]), .energy_wake_in(ev[2]),
        .host_ready_in(host_ready), .pm_clear_wr_in(pm_wr),
        .pm_clear_code_in(pm_code), .irq_n_out(irq_n));
    function automatic logic [15:0] en_exp(input logic [15:0] v);
        return v & 16'hfffd;
    endfunction : en_exp
    function automatic logic [3:0] wake_code(input int n);
        return 4'h1 << (n - 2);
    endfunction : wake_code
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic rs(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        logic        ok;
        hm.rd(a, v, ok);
        check({15'h0000, ok}, 16'h0001);
        check(v, exp);
    endtask : rs
    task automatic ci(input logic e);
        #1;
        check({15'h0000, irq_n}, {15'h0000, e});
    endtask : ci
    // A source pulses for a random width; the link level only toggles.
    task automatic pulse(input int n);
        @(posedge clock_in);
        ev[n] <= ~ev[n];
        repeat ($urandom_range(3, 1)) @(posedge clock_in);
        if (n != 15) ev[n] <= 1'b0;
        repeat (3) @(posedge clock_in);
    endtask : pulse
    task automatic pmclr(input logic [3:0] c);
        @(posedge clock_in);
        pm_wr   <= 1'b1;
        pm_code <= c;
        @(posedge clock_in);
        pm_wr   <= 1'b0;
        pm_code <= ~c;
    endtask : pmclr
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // Main sequence: reset, registers, every source, delayed energy.
    initial begin
        void'($urandom(32'hb7de));
        repeat (6) @(posedge clock_in);
        nrst_in <= 1'b1;
        rs(8'h90, 16'h0000);
        rs(8'h92, 16'h0000);
        ci(1'b1);
        for (int i = 0; i < 6; i++) begin
            d = 16'($urandom);
            hm.wr(8'h90, d);
            rs(8'h90, en_exp(d));
            rs(8'h94 + 8'($urandom_range(63, 0)), 16'h0000);
        end
        $display("test registers done");
        foreach (srcs[k]) begin
            b = srcs[k];
            hm.wr(8'h90, 16'h1 << b);
            pulse(b);
            ci(1'b0);
            hm.wr(8'h90, ~(16'h1 << b) & 16'hfffe);
            repeat (2) @(posedge clock_in);
            ci(1'b1);
            rs(8'h92, 16'h1 << b);
            rs(8'h92, 16'h1 << b);
            hm.wr(8'h92, ~(16'h1 << b));
            rs(8'h92, 16'h1 << b);
            hm.wr(8'h92, 16'h1 << b);
            if (b < 6) begin
                rs(8'h92, 16'h1 << b);
                wc = wake_code(b);
                pmclr({wc[0], wc[3:1]});
                rs(8'h92, 16'h1 << b);
                pmclr(wc);
            end
            rs(8'h92, 16'h0000);
        end
        $display("test sources done");
        hm.wr(8'h90, 16'h0001);
        pulse(2);
        ci(1'b1);
        @(posedge clock_in);
        host_ready <= 1'b1;
        repeat (3) @(posedge clock_in);
        ci(1'b0);
        pmclr(4'h1);
        repeat (2) @(posedge clock_in);
        ci(1'b1);
        $display("test delayed energy done");
        summarize();
    end
endmodule : tb_interrupt_enable_status
